// [rtl/gsrb_pkg.sv]
// constants of the gauge standard read-out bank
package gsrb_pkg;
	// word offsets, low byte at the even address
	localparam logic [7:0] OFF_PACK_VOLTAGE = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0A;
	localparam logic [7:0] OFF_NOM_REMAIN = 8'h0C;
	localparam logic [7:0] OFF_FULL_AVAIL = 8'h0E;
	localparam logic [7:0] OFF_REMAIN_SEL = 8'h10;
	localparam logic [7:0] OFF_FULL_SEL = 8'h12;
	localparam logic [7:0] OFF_AVG_CURRENT = 8'h14;
	localparam logic [7:0] OFF_MIN_EMPTY = 8'h16;
	localparam logic [7:0] OFF_SMOOTH_FULL = 8'h18;
	localparam logic [7:0] OFF_COMP_FULL = 8'h1C;
	localparam logic [7:0] OFF_MAX_DISCH = 8'h1E;
	localparam logic [7:0] OFF_COMP_REMAIN = 8'h20;
	localparam logic [7:0] OFF_SMOOTH_REMAIN = 8'h22;
	localparam logic [7:0] OFF_TRIP_SET = 8'h24;
	localparam logic [7:0] OFF_TRIP_CLEAR = 8'h26;
	localparam logic [7:0] OFF_DIE_TEMP = 8'h28;
	localparam logic [7:0] OFF_CYCLES = 8'h2A;
	localparam logic [7:0] OFF_CHARGE_PCT = 8'h2C;
	localparam logic [7:0] OFF_HEALTH_PCT = 8'h2E;
	localparam logic [7:0] OFF_CHG_VOLT = 8'h30;
	// status word bit positions
	localparam int BIT_VOLT_HIGH = 13;
	localparam int BIT_VOLT_LOW = 12;
	localparam int BIT_CHG_BLOCK = 11;
	localparam int BIT_FULL = 9;
	localparam int BIT_CHG_PAUSE = 7;
	localparam int BIT_PEAK_CHANGE = 4;
	localparam int BIT_FAST_CHG = 3;
	localparam int BIT_FIRST_THR = 2;
	localparam int BIT_FINAL_THR = 1;
	localparam int BIT_DISCHARGE = 0;
	// value limits and codes
	localparam logic [15:0] PACK_MV_MAX = 16'h1770;
	localparam logic [15:0] MINUTES_IDLE = 16'hFFFF;
	localparam logic [15:0] CYCLES_MAX = 16'hFFFF;
	localparam logic [22:0] PCT_MAX = 23'h000064;
	localparam logic [15:0] PCT_SCALE = 16'h0064;
	localparam logic [7:0] FULL_THR_NONE = 8'hFF;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	// refresh timing
	localparam int CLK_HZ = 50_000_000;
	localparam int REFRESH_S = 1;
	localparam int REFRESH_CYCLES = CLK_HZ * REFRESH_S;
	localparam int SLEEP_REFRESH_S = 20;
	localparam logic [4:0] SLEEP_TICKS = 5'(SLEEP_REFRESH_S);
	localparam int DIV_STEPS = 23;
	// power modes
	typedef enum logic [1:0] {
		PM_NORMAL = 2'h0,
		PM_SLEEP = 2'h1,
		PM_FULLSLEEP = 2'h2
	} gsrb_power_type;
	// shared divider states, gray along the loop
	typedef enum logic [1:0] {
		DV_IDLE = 2'h0,
		DV_LOAD = 2'h1,
		DV_RUN = 2'h3,
		DV_DONE = 2'h2
	} gsrb_div_type;
endpackage

// [rtl/gsrb_bank.sv]
// gauge standard read-out bank: word commands, status flags, trip thresholds
`timescale 1ns/1ps
`default_nettype none
module gsrb_bank #(
	parameter int REFRESH_CYCLES = gsrb_pkg::REFRESH_CYCLES
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	// serial command port, byte wide
	input wire logic [7:0] cmd_addr,
	input wire logic cmd_rd,
	input wire logic cmd_wr,
	input wire logic [7:0] cmd_wdata,
	output logic [7:0] rd_data_q,
	output logic rd_valid_q,
	output logic trip_alert_q,
	// measurements and settings from the gauging core
	input wire logic [15:0] meas_voltage_mv,
	input wire logic [15:0] cell_temp,
	input wire logic [15:0] die_temp_in,
	input wire logic [15:0] low_temp_limit,
	input wire logic [15:0] upper_inhibit_temp,
	input wire logic [15:0] upper_suspend_temp,
	input wire logic charging_active,
	input wire logic discharge_flag,
	input wire logic charge_terminated,
	input wire logic [7:0] full_threshold_percent,
	input wire logic fast_charge_allowed_flag,
	input wire logic pack_voltage_high_flag,
	input wire logic pack_voltage_low_flag,
	input wire logic [15:0] first_level,
	input wire logic [15:0] final_level,
	input wire logic [15:0] nominal_in,
	input wire logic [15:0] full_avail_in,
	input wire logic [15:0] comp_remaining_in,
	input wire logic [15:0] comp_full_in,
	input wire logic [15:0] smooth_remaining_in,
	input wire logic smoothing_select,
	input wire logic [15:0] current_ma_in,
	input wire logic [1:0] power_mode,
	input wire logic [15:0] minutes_in,
	input wire logic [15:0] imax_in,
	input wire logic [15:0] imax_delta,
	input wire logic imax_clear,
	input wire logic [15:0] pred_full_room,
	input wire logic [15:0] design_capacity,
	input wire logic discharge_mah_pulse,
	input wire logic [15:0] cycle_discharge_threshold,
	input wire logic [2:0] temp_range,
	input wire logic [15:0] range_voltage
);
	logic [15:0] voltage_q, status_w, smooth_full_q, avg_current_q, imax_q;
	logic [15:0] trip_set_q, trip_clear_q, cycles_q, cycle_acc_q, chg_volt_q;
	logic [15:0] remain_sel, full_sel, minutes_q, imax_diff;
	logic [15:0] imax_ref_q; // maximum current held when the peak flag last fired
	logic [15:0] rd_word_w; // word under the present command address
	logic [7:0] soc_q, soh_q, wr_low_q, snap_hi_q;
	logic block_q, pause_q, full_q, term_seen_q, peak_q, first_q, final_q;
	logic [31:0] sec_cnt_q; // one second divider
	logic sec_tick_q; // one-cycle enable each second
	logic [4:0] sleep_cnt_q; // seconds since last refresh when asleep
	logic [2:0] range_q; // last temperature range seen
	logic range_init_q; // first range not yet captured
	gsrb_pkg::gsrb_div_type dv_q;
	logic dv_job_q; // 0 charge percent, 1 health percent
	logic [22:0] dv_num_q, dv_quo_q;
	logic [16:0] dv_rem_q;
	logic [15:0] dv_den_q;
	logic [4:0] dv_cnt_q;
	logic [16:0] dv_try;

	// word presented at an even command address; unmapped gives zero
	function automatic logic [15:0] word_at(input logic [7:0] a);
		unique case ({a[7:1], 1'b0})
			gsrb_pkg::OFF_PACK_VOLTAGE: word_at = voltage_q;
			gsrb_pkg::OFF_STATUS: word_at = status_w;
			gsrb_pkg::OFF_NOM_REMAIN: word_at = nominal_in;
			gsrb_pkg::OFF_FULL_AVAIL: word_at = full_avail_in;
			gsrb_pkg::OFF_REMAIN_SEL: word_at = remain_sel;
			gsrb_pkg::OFF_FULL_SEL: word_at = full_sel;
			gsrb_pkg::OFF_AVG_CURRENT: word_at = avg_current_q;
			gsrb_pkg::OFF_MIN_EMPTY: word_at = minutes_q;
			gsrb_pkg::OFF_SMOOTH_FULL: word_at = smooth_full_q;
			gsrb_pkg::OFF_COMP_FULL: word_at = comp_full_in;
			gsrb_pkg::OFF_MAX_DISCH: word_at = imax_q;
			gsrb_pkg::OFF_COMP_REMAIN: word_at = comp_remaining_in;
			gsrb_pkg::OFF_SMOOTH_REMAIN: word_at = smooth_remaining_in;
			gsrb_pkg::OFF_TRIP_SET: word_at = trip_set_q;
			gsrb_pkg::OFF_TRIP_CLEAR: word_at = trip_clear_q;
			gsrb_pkg::OFF_DIE_TEMP: word_at = die_temp_in;
			gsrb_pkg::OFF_CYCLES: word_at = cycles_q;
			gsrb_pkg::OFF_CHARGE_PCT: word_at = {8'h00, soc_q};
			gsrb_pkg::OFF_HEALTH_PCT: word_at = {8'h00, soh_q};
			gsrb_pkg::OFF_CHG_VOLT: word_at = chg_volt_q;
			default: word_at = gsrb_pkg::WORD_RESET;
		endcase
	endfunction

	// smoothing select picks filtered or unfiltered capacity
	assign remain_sel = smoothing_select ? smooth_remaining_in : comp_remaining_in;
	assign full_sel = smoothing_select ? smooth_full_q : comp_full_in;
	assign imax_diff = (imax_in > imax_ref_q) ? imax_in - imax_ref_q : imax_ref_q - imax_in;

	// word lookup; always_comb also wakes on what the function reads inside
	always_comb begin
		rd_word_w = word_at(cmd_addr);
	end

	// status word assembly, reserved bits read zero
	always_comb begin
		status_w = gsrb_pkg::WORD_RESET;
		status_w[gsrb_pkg::BIT_VOLT_HIGH] = pack_voltage_high_flag;
		status_w[gsrb_pkg::BIT_VOLT_LOW] = pack_voltage_low_flag;
		status_w[gsrb_pkg::BIT_CHG_BLOCK] = block_q;
		status_w[gsrb_pkg::BIT_FULL] = full_q;
		status_w[gsrb_pkg::BIT_CHG_PAUSE] = pause_q;
		status_w[gsrb_pkg::BIT_PEAK_CHANGE] = peak_q;
		status_w[gsrb_pkg::BIT_FAST_CHG] = fast_charge_allowed_flag;
		status_w[gsrb_pkg::BIT_FIRST_THR] = first_q;
		status_w[gsrb_pkg::BIT_FINAL_THR] = final_q;
		status_w[gsrb_pkg::BIT_DISCHARGE] = discharge_flag;
	end

	// read path: even byte freezes the whole word so the odd byte matches it
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			rd_data_q <= 8'h00;
			rd_valid_q <= 1'b0;
			snap_hi_q <= 8'h00;
		end else begin
			rd_valid_q <= cmd_rd;
			if (cmd_rd && !cmd_addr[0]) begin
				rd_data_q <= rd_word_w[7:0];
				snap_hi_q <= rd_word_w[15:8];
			end else if (cmd_rd) begin
				rd_data_q <= snap_hi_q;
			end
		end
	end

	// write path: low byte waits, high byte commits the word at once
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			wr_low_q <= 8'h00;
			trip_set_q <= gsrb_pkg::WORD_RESET;
			trip_clear_q <= gsrb_pkg::WORD_RESET;
		end else if (cmd_wr) begin
			if (!cmd_addr[0]) begin
				wr_low_q <= cmd_wdata;
			end else if ({cmd_addr[7:1], 1'b0} == gsrb_pkg::OFF_TRIP_SET) begin
				trip_set_q <= {cmd_wdata, wr_low_q};
			end else if ({cmd_addr[7:1], 1'b0} == gsrb_pkg::OFF_TRIP_CLEAR) begin
				trip_clear_q <= {cmd_wdata, wr_low_q};
			end
		end
	end

	// trip alert: falls below set while discharging, released above clear while charging
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			trip_alert_q <= 1'b0;
		end else if (discharge_flag && remain_sel < trip_set_q) begin
			trip_alert_q <= 1'b1;
		end else if (charging_active && remain_sel > trip_clear_q) begin
			trip_alert_q <= 1'b0;
		end
	end

	// voltage capped so a bad conversion never reads above range
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			voltage_q <= gsrb_pkg::WORD_RESET;
		end else if (meas_voltage_mv > gsrb_pkg::PACK_MV_MAX) begin
			voltage_q <= gsrb_pkg::PACK_MV_MAX;
		end else begin
			voltage_q <= meas_voltage_mv;
		end
	end

	// temperature guarded charging flags
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			block_q <= 1'b0;
			pause_q <= 1'b0;
		end else begin
			block_q <= !charging_active && (cell_temp < low_temp_limit ||
				cell_temp > upper_inhibit_temp);
			pause_q <= charging_active && (cell_temp < low_temp_limit ||
				cell_temp > upper_suspend_temp);
		end
	end

	// full flag; termination is remembered until discharge starts
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			term_seen_q <= 1'b0;
			full_q <= 1'b0;
		end else begin
			if (charge_terminated) begin
				term_seen_q <= 1'b1;
			end else if (discharge_flag) begin
				term_seen_q <= 1'b0;
			end
			if (full_threshold_percent == gsrb_pkg::FULL_THR_NONE) begin
				full_q <= term_seen_q || charge_terminated;
			end else begin
				full_q <= soc_q > full_threshold_percent;
			end
		end
	end

	// peak current flag against the held reference: set beats clear in the same cycle
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			peak_q <= 1'b0;
			imax_ref_q <= gsrb_pkg::WORD_RESET;
		end else if (imax_diff >= imax_delta && imax_delta != gsrb_pkg::WORD_RESET) begin
			peak_q <= 1'b1;
			imax_ref_q <= imax_in;
		end else if (imax_clear) begin
			peak_q <= 1'b0;
		end
	end

	// maximum current word follows the core, not only the flag reference
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			imax_q <= gsrb_pkg::WORD_RESET;
		end else begin
			imax_q <= imax_in;
		end
	end

	// charge level thresholds on the selected remaining capacity
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			first_q <= 1'b0;
			final_q <= 1'b0;
		end else begin
			first_q <= remain_sel <= first_level;
			final_q <= remain_sel <= final_level;
		end
	end

	// minutes word forced to all ones when not discharging
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			minutes_q <= gsrb_pkg::MINUTES_IDLE;
		end else begin
			minutes_q <= discharge_flag ? minutes_in : gsrb_pkg::MINUTES_IDLE;
		end
	end

	// second divider; a parameter so simulation can shorten it
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			sec_cnt_q <= 32'h0;
			sec_tick_q <= 1'b0;
		end else if (sec_cnt_q >= 32'(REFRESH_CYCLES - 1)) begin
			sec_cnt_q <= 32'h0;
			sec_tick_q <= 1'b1;
		end else begin
			sec_cnt_q <= sec_cnt_q + 32'h1;
			sec_tick_q <= 1'b0;
		end
	end

	// average current refresh, every tick awake, every twentieth asleep
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			sleep_cnt_q <= 5'h00;
			avg_current_q <= gsrb_pkg::WORD_RESET;
		end else if (sec_tick_q) begin
			if (power_mode == gsrb_pkg::PM_NORMAL) begin
				sleep_cnt_q <= 5'h00;
				avg_current_q <= current_ma_in;
			end else if (sleep_cnt_q >= gsrb_pkg::SLEEP_TICKS - 5'h01) begin
				sleep_cnt_q <= 5'h00;
				avg_current_q <= current_ma_in;
			end else begin
				sleep_cnt_q <= sleep_cnt_q + 5'h01;
			end
		end
	end

	// smoothed full capacity walks one unit per second toward compensated value while charging
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			smooth_full_q <= gsrb_pkg::WORD_RESET;
		end else if (smooth_full_q == gsrb_pkg::WORD_RESET) begin
			smooth_full_q <= comp_full_in; // seeds from the first valid value
		end else if (sec_tick_q && charging_active) begin
			if (smooth_full_q < comp_full_in) begin
				smooth_full_q <= smooth_full_q + 16'h0001;
			end else if (smooth_full_q > comp_full_in) begin
				smooth_full_q <= smooth_full_q - 16'h0001;
			end
		end
	end

	// cycle counter: saturates rather than wrapping to zero
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			cycle_acc_q <= gsrb_pkg::WORD_RESET;
			cycles_q <= gsrb_pkg::WORD_RESET;
		end else if (cycle_acc_q >= cycle_discharge_threshold &&
			cycle_discharge_threshold != gsrb_pkg::WORD_RESET) begin
			cycle_acc_q <= cycle_acc_q - cycle_discharge_threshold;
			if (cycles_q != gsrb_pkg::CYCLES_MAX) begin
				cycles_q <= cycles_q + 16'h0001;
			end
		end else if (discharge_mah_pulse && cycle_acc_q != gsrb_pkg::CYCLES_MAX) begin
			cycle_acc_q <= cycle_acc_q + 16'h0001;
		end
	end

	// charge voltage latched on the first cycle after reset and when the temperature range moves
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			range_q <= 3'h0;
			range_init_q <= 1'b1;
			chg_volt_q <= gsrb_pkg::WORD_RESET;
		end else if (range_init_q || temp_range != range_q) begin
			range_q <= temp_range;
			range_init_q <= 1'b0;
			chg_volt_q <= range_voltage;
		end
	end

	// shared restoring divider; one divider for two percentages saves area
	assign dv_try = {dv_rem_q[15:0], dv_num_q[22]};
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			dv_q <= gsrb_pkg::DV_IDLE;
			dv_job_q <= 1'b0;
			dv_num_q <= 23'h0;
			dv_quo_q <= 23'h0;
			dv_rem_q <= 17'h0;
			dv_den_q <= 16'h0;
			dv_cnt_q <= 5'h0;
			soc_q <= 8'h00;
			soh_q <= 8'h00;
		end else begin
			unique case (dv_q)
				gsrb_pkg::DV_IDLE: begin
					dv_q <= gsrb_pkg::DV_LOAD;
				end
				gsrb_pkg::DV_LOAD: begin
					dv_num_q <= 23'(dv_job_q ? pred_full_room : remain_sel) *
						23'(gsrb_pkg::PCT_SCALE);
					dv_den_q <= dv_job_q ? design_capacity : full_sel;
					dv_rem_q <= 17'h0;
					dv_quo_q <= 23'h0;
					dv_cnt_q <= 5'(gsrb_pkg::DIV_STEPS);
					dv_q <= gsrb_pkg::DV_RUN;
				end
				gsrb_pkg::DV_RUN: begin
					if (dv_try >= {1'b0, dv_den_q}) begin
						dv_rem_q <= dv_try - {1'b0, dv_den_q};
						dv_quo_q <= {dv_quo_q[21:0], 1'b1};
					end else begin
						dv_rem_q <= dv_try;
						dv_quo_q <= {dv_quo_q[21:0], 1'b0};
					end
					dv_num_q <= {dv_num_q[21:0], 1'b0};
					dv_cnt_q <= dv_cnt_q - 5'h1;
					if (dv_cnt_q == 5'h1) begin
						dv_q <= gsrb_pkg::DV_DONE;
					end
				end
				gsrb_pkg::DV_DONE: begin
					// zero divisor reads as zero, overshoot reads as the cap
					if (dv_den_q == 16'h0) begin
						if (dv_job_q) soh_q <= 8'h00;
						else soc_q <= 8'h00;
					end else if (dv_job_q) begin
						soh_q <= (dv_quo_q > gsrb_pkg::PCT_MAX) ?
							gsrb_pkg::PCT_MAX[7:0] : dv_quo_q[7:0];
					end else begin
						soc_q <= (dv_quo_q > gsrb_pkg::PCT_MAX) ?
							gsrb_pkg::PCT_MAX[7:0] : dv_quo_q[7:0];
					end
					dv_job_q <= !dv_job_q;
					dv_q <= gsrb_pkg::DV_IDLE;
				end
			endcase
		end
	end

	// checks on the logic above
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	sequence even_read_s;
		cmd_rd && !cmd_addr[0];
	endsequence
	sequence odd_read_s;
		cmd_rd && cmd_addr[0];
	endsequence

	volt_cap_a: assert property (##1 voltage_q <= gsrb_pkg::PACK_MV_MAX)
		else $error("voltage above cap");
	status_map_a: assert property (status_w[15:14] == 2'b00 && status_w[10] == 1'b0 &&
		status_w[8] == 1'b0 && status_w[6:5] == 2'b00)
		else $error("reserved status bit set");
	block_flag_a: assert property (!charging_active && cell_temp > upper_inhibit_temp
		|=> block_q)
		else $error("charge block not set");
	pause_flag_a: assert property (charging_active && cell_temp < low_temp_limit
		|=> pause_q)
		else $error("charge pause not set");
	minutes_idle_a: assert property (!discharge_flag |=> minutes_q == gsrb_pkg::MINUTES_IDLE)
		else $error("minutes not all ones");
	avg_hold_a: assert property (!sec_tick_q |=> $stable(avg_current_q))
		else $error("average current changed off tick");
	pct_cap_a: assert property (soc_q <= 8'h64 && soh_q <= 8'h64)
		else $error("percentage above cap");
	cycle_step_a: assert property (cycles_q != gsrb_pkg::CYCLES_MAX
		|=> cycles_q == $past(cycles_q) || cycles_q == $past(cycles_q) + 16'h0001)
		else $error("cycle count jumped");
	trip_write_a: assert property (cmd_wr && cmd_addr == 8'h25 ##0 1'b1
		|=> trip_set_q == {$past(cmd_wdata), $past(wr_low_q)})
		else $error("trip set not written");
	snapshot_a: assert property (even_read_s ##1 odd_read_s
		|=> rd_valid_q && rd_data_q == $past(rd_word_w[15:8], 2))
		else $error("word pair not coherent");
endmodule
`default_nettype wire

// [dv/gsrb_host_model.sv]
// host model: drives the byte command port of the read-out bank
`timescale 1ns/1ps
`default_nettype none
module gsrb_host_model (
	input wire logic clk_sys,
	output logic [7:0] cmd_addr,
	output logic cmd_rd,
	output logic cmd_wr,
	output logic [7:0] cmd_wdata,
	input wire logic [7:0] rd_data_q,
	input wire logic rd_valid_q
);
	// idle address and data lines carry a non-zero pattern so a stale zero never passes
	initial begin
		cmd_addr = 8'hFF;
		cmd_rd = 1'b0;
		cmd_wr = 1'b0;
		cmd_wdata = 8'hA5;
	end
	// one byte read; the answer is awaited under a bound of four cycles
	task automatic rd_byte(input logic [7:0] a, output logic [7:0] d, output logic ok);
		ok = 1'b0;
		d = 8'h00;
		@(negedge clk_sys);
		cmd_addr = a;
		cmd_rd = 1'b1;
		@(negedge clk_sys);
		cmd_rd = 1'b0;
		cmd_addr = ~a;
		for (int i = 0; i < 4; i++) begin
			// the pulse lasts one cycle, so it is taken the first time it is seen
			if (!ok && rd_valid_q === 1'b1) begin
				d = rd_data_q;
				ok = 1'b1;
			end
			@(negedge clk_sys);
		end
	endtask
	// even byte first so the high byte comes from the same snapshot
	// back to back: the strobe stays up while the address moves to the odd byte
	task automatic rd_word(input logic [7:0] a, output logic [15:0] d, output logic ok);
		logic ok_lo;
		@(negedge clk_sys);
		cmd_addr = a;
		cmd_rd = 1'b1;
		@(negedge clk_sys);
		// the even answer stands for this one cycle
		ok_lo = (rd_valid_q === 1'b1);
		d[7:0] = rd_data_q;
		cmd_addr = a | 8'h01;
		@(negedge clk_sys);
		ok = ok_lo && (rd_valid_q === 1'b1);
		d[15:8] = rd_data_q;
		cmd_rd = 1'b0;
		cmd_addr = ~a;
	endtask
	// low byte at the even address, the odd byte commits the word
	task automatic wr_word(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk_sys);
		cmd_addr = a;
		cmd_wdata = d[7:0];
		cmd_wr = 1'b1;
		@(negedge clk_sys);
		cmd_addr = a | 8'h01;
		cmd_wdata = d[15:8];
		@(negedge clk_sys);
		cmd_wr = 1'b0;
		cmd_addr = ~a;
		cmd_wdata = ~d[15:8];
	endtask
endmodule
`default_nettype wire

// [dv/gsrb_bank_tb_top.sv]
// testbench of the read-out bank: word reads, threshold writes, status flags
`timescale 1ns/1ps
`default_nettype none
module gsrb_bank_tb_top;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] cmd_addr, cmd_wdata, rd_data_q, full_threshold_percent;
	logic cmd_rd, cmd_wr, rd_valid_q, trip_alert_q, charging_active, discharge_flag;
	logic charge_terminated, fast_charge_allowed_flag, pack_voltage_high_flag;
	logic pack_voltage_low_flag, smoothing_select, imax_clear, discharge_mah_pulse;
	logic [1:0] power_mode;
	logic [2:0] temp_range;
	logic [15:0] meas_voltage_mv, cell_temp, die_temp_in, low_temp_limit, upper_inhibit_temp;
	logic [15:0] upper_suspend_temp, first_level, final_level, nominal_in, full_avail_in;
	logic [15:0] comp_remaining_in, comp_full_in, smooth_remaining_in, current_ma_in;
	logic [15:0] minutes_in, imax_in, imax_delta, pred_full_room, design_capacity;
	logic [15:0] cycle_discharge_threshold, range_voltage;
	int errors = 0;
	int total_checks = 0;
	logic [15:0] got;
	logic [7:0] got_b;
	logic ok;
	// plain words and the values the inputs below make them show
	logic [7:0] tbl_addr [12] = '{8'h0C, 8'h0E, 8'h1C, 8'h1E, 8'h20, 8'h22,
		8'h28, 8'h10, 8'h12, 8'h30, 8'h2C, 8'h2E};
	logic [15:0] tbl_exp [12] = '{16'h0BB8, 16'h0C80, 16'h00C8, 16'h01F4, 16'h0032, 16'h002D,
		16'h0B9A, 16'h0032, 16'h00C8, 16'h1068, 16'h0019, 16'h005A};
	// 20 ns period
	always #10 clk_sys = ~clk_sys;
	// short refresh count keeps the average current test brief
	gsrb_bank #(.REFRESH_CYCLES(50)) u_gsrb_bank (.clk_sys, .reset_n, .cmd_addr, .cmd_rd,
		.cmd_wr, .cmd_wdata, .rd_data_q, .rd_valid_q, .trip_alert_q, .meas_voltage_mv,
		.cell_temp, .die_temp_in, .low_temp_limit, .upper_inhibit_temp, .upper_suspend_temp,
		.charging_active, .discharge_flag, .charge_terminated, .full_threshold_percent,
		.fast_charge_allowed_flag, .pack_voltage_high_flag, .pack_voltage_low_flag,
		.first_level, .final_level, .nominal_in, .full_avail_in, .comp_remaining_in,
		.comp_full_in, .smooth_remaining_in, .smoothing_select, .current_ma_in, .power_mode,
		.minutes_in, .imax_in, .imax_delta, .imax_clear, .pred_full_room, .design_capacity,
		.discharge_mah_pulse, .cycle_discharge_threshold, .temp_range, .range_voltage);
	gsrb_host_model u_gsrb_host_model (.clk_sys, .cmd_addr, .cmd_rd, .cmd_wr, .cmd_wdata,
		.rd_data_q, .rd_valid_q);
	// verdict and end of run, also reached by a word read that gets no answer
	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// word comparison, case equality so unknowns fail
	task automatic check16(input string name, input logic [15:0] exp, input logic [15:0] seen);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// read a word through the host and compare it
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
		u_gsrb_host_model.rd_word(a, got, ok);
		if (ok !== 1'b1) begin
			errors++;
			$display("wrong value read answer at %h expected 1 seen 0", a);
			close_out();
		end else begin
			check16($sformatf("word %h", a), exp, got);
		end
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// main sequence
	initial begin
		{charging_active, charge_terminated, pack_voltage_low_flag, smoothing_select} = '0;
		{imax_clear, discharge_mah_pulse, power_mode, first_level, final_level, imax_delta} = '0;
		{discharge_flag, fast_charge_allowed_flag, pack_voltage_high_flag} = 3'h7;
		full_threshold_percent = 8'hFF;
		meas_voltage_mv = 16'h1B58;
		cell_temp = 16'h000A;
		low_temp_limit = 16'h0064;
		upper_inhibit_temp = 16'h01F4;
		upper_suspend_temp = 16'h0190;
		nominal_in = 16'h0BB8;
		full_avail_in = 16'h0C80;
		comp_remaining_in = 16'h0032;
		comp_full_in = 16'h00C8;
		smooth_remaining_in = 16'h002D;
		minutes_in = 16'h0078;
		imax_in = 16'h01F4;
		die_temp_in = 16'h0B9A;
		pred_full_room = 16'h005A;
		design_capacity = 16'h0064;
		cycle_discharge_threshold = 16'h0003;
		range_voltage = 16'h1068;
		temp_range = 3'h1;
		current_ma_in = 16'hFF38;
		wait_cyc(3);
		reset_n = 1'b1;
		rd_chk(8'h24, 16'h0000);
		rd_chk(8'h08, 16'h1770);
		meas_voltage_mv = 16'h04D2;
		wait_cyc(2);
		rd_chk(8'h08, 16'h04D2);
		// an odd byte alone still gives the high byte of the last even read
		meas_voltage_mv = 16'h1234;
		wait_cyc(2);
		u_gsrb_host_model.rd_byte(8'h09, got_b, ok);
		check16("odd byte answer", 16'h0001, {15'h0000, ok});
		check16("odd byte", 16'h0004, {8'h00, got_b});
		meas_voltage_mv = 16'h04D2;
		rd_chk(8'h0A, 16'h2809);
		rd_chk(8'h16, 16'h0078);
		// let both percentages and one refresh tick settle
		wait_cyc(120);
		rd_chk(8'h14, 16'hFF38);
		// asleep the word holds for twenty ticks, in both sleep modes
		power_mode = 2'h1;
		current_ma_in = 16'h0064;
		wait_cyc(60);
		rd_chk(8'h14, 16'hFF38);
		power_mode = 2'h2;
		wait_cyc(1000);
		rd_chk(8'h14, 16'h0064);
		for (int i = 0; i < 12; i++) begin
			rd_chk(tbl_addr[i], tbl_exp[i]);
		end
		smoothing_select = 1'b1;
		wait_cyc(2);
		rd_chk(8'h10, 16'h002D);
		smoothing_select = 1'b0;
		// three one-mAh pulses reach the threshold exactly
		repeat (3) begin
			discharge_mah_pulse = 1'b1;
			wait_cyc(1);
			discharge_mah_pulse = 1'b0;
			wait_cyc(1);
		end
		wait_cyc(2);
		rd_chk(8'h2A, 16'h0001);
		u_gsrb_host_model.wr_word(8'h24, 16'h0064);
		rd_chk(8'h24, 16'h0064);
		u_gsrb_host_model.wr_word(8'h26, 16'h0028);
		rd_chk(8'h26, 16'h0028);
		// read-only word ignores writes; unmapped word reads zero
		u_gsrb_host_model.wr_word(8'h08, 16'h0000);
		rd_chk(8'h08, 16'h04D2);
		rd_chk(8'h1A, 16'h0000);
		wait_cyc(3);
		check16("trip alert", 16'h0001, {15'h0000, trip_alert_q});
		discharge_flag = 1'b0;
		charging_active = 1'b1;
		pack_voltage_low_flag = 1'b1;
		wait_cyc(3);
		check16("trip alert", 16'h0000, {15'h0000, trip_alert_q});
		rd_chk(8'h0A, 16'h3088);
		// termination under the none setting, then percent settings at and below 25
		charge_terminated = 1'b1;
		wait_cyc(1);
		charge_terminated = 1'b0;
		wait_cyc(2);
		rd_chk(8'h0A, 16'h3288);
		full_threshold_percent = 8'h19;
		wait_cyc(3);
		rd_chk(8'h0A, 16'h3088);
		full_threshold_percent = 8'h14;
		wait_cyc(3);
		rd_chk(8'h0A, 16'h3288);
		// peak flag: first step from zero, cleared, small step, large step
		imax_delta = 16'h0064;
		wait_cyc(3);
		rd_chk(8'h0A, 16'h3298);
		imax_clear = 1'b1;
		wait_cyc(1);
		imax_clear = 1'b0;
		imax_in = 16'h0220;
		wait_cyc(3);
		rd_chk(8'h0A, 16'h3288);
		imax_in = 16'h0258;
		first_level = 16'h0032;
		final_level = 16'h0031;
		wait_cyc(3);
		rd_chk(8'h0A, 16'h329C);
		final_level = 16'h0032;
		wait_cyc(3);
		rd_chk(8'h0A, 16'h329E);
		temp_range = 3'h2;
		range_voltage = 16'h0FA0;
		wait_cyc(3);
		rd_chk(8'h30, 16'h0FA0);
		// same range: a new profile value is not taken
		range_voltage = 16'h1000;
		wait_cyc(3);
		rd_chk(8'h30, 16'h0FA0);
		// smoothed full capacity steps toward the compensated value while charging
		comp_full_in = 16'h00CA;
		wait_cyc(110);
		rd_chk(8'h18, 16'h00CA);
		smoothing_select = 1'b1;
		wait_cyc(2);
		rd_chk(8'h12, 16'h00CA);
		// reset in mid-run: trip set clears, charge voltage is captured again
		reset_n = 1'b0;
		wait_cyc(2);
		reset_n = 1'b1;
		rd_chk(8'h24, 16'h0000);
		rd_chk(8'h30, 16'h1000);
		close_out();
	end
endmodule
`default_nettype wire
